// File: spi_master_regs.svh
`ifndef SPI_MASTER_REGS_SVH
`define SPI_MASTER_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SERIAL_MASTER_CONFIG 8'h00
`define OFS_SERIAL_TX_BYTE_LOW 8'h01
`define OFS_SERIAL_TX_BYTE_MID 8'h02
`define OFS_SERIAL_TX_BYTE_HIGH 8'h03
`define OFS_SERIAL_EXECUTE_CONTROL 8'h04
`define OFS_SERIAL_RX_BYTE_LOW 8'h05
`define OFS_SERIAL_RX_BYTE_MID 8'h06
`define OFS_SERIAL_RX_BYTE_HIGH 8'h07
`define OFS_PIN_FUNCTION_CONFIG 8'h08
`define OFS_COMM_DIAGNOSTIC_CONTROL 8'h09
`define OFS_SERIAL_STATUS 8'h0a

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_LEN_MSB 4
`define CFG_LEN_LSB 0
`define CFG_CPHA_BIT 5
`define CFG_CPOL_BIT 6
`define EXE_GO_BIT 0
`define EXE_SS_BIT 1
`define PINCFG_MASTER_EN_BIT 0
`define DIAG_LOOPBACK_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_SS_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SERIAL_MASTER_CONFIG 8'h08
`define RST_SERIAL_EXECUTE_CONTROL 8'h02
`define RST_BYTE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCLK_PERIOD_NS 20
`define SCLK_HALF_NS 80
`define SCLK_HALF_CYCLES ((`SCLK_HALF_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define MAX_XFER_BITS 24

`endif

// File: spi_master_pkg.sv
package spi_master_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } xfer_state_t;

endpackage

// File: sync_two_flop.sv
`timescale 1ns/100ps
module sync_two_flop (
    input wire logic mclk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// File: half_period_ticker.sv
`timescale 1ns/100ps
module half_period_ticker #(
    parameter int HALF_DIV = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_tick;

    if (HALF_DIV < 1 || HALF_DIV > 65535) begin : bad_half_div
        $error("HALF_DIV out of range");
    end

    // Restarts while idle so every frame opens with a full half period
    always_comb begin
        next_cnt = 16'h0000;
        next_tick = 1'b0;
        if (run) begin
            if (cnt == 16'(HALF_DIV - 1)) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// File: register_driven_spi_master.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "spi_master_regs.svh"

// Contract
// - Pins act as master port only while master enable bit is 1.
// - Device generates serial clock itself and drives it out.
// - Outgoing bits go on MOSI, incoming bits captured from MISO.
// - Slave select pin follows the select control field.
// - Clock polarity bit chooses non-inverted or inverted serial clock.
// - Phase bit chooses sampling on leading or trailing edge.
// - Transfer is exactly length-field bits, one to twenty-four.
// - Three transmit bytes, first is least, third most significant.
// - Execute write 0x01 selects slave low and starts shifting.
// - Execute write 0x02 drives select high, no new transfer.
// - Received bits land in three receive bytes after transfer.
// - Loopback routes transmit data internally to receive input.
// - Loopback keeps all external serial pins frozen.
// - Entering loopback latches select pin at current control value.
// - Loopback leaves receive bytes equal to the low length-field bits of transmit bytes, upper bits zero.
module register_driven_spi_master #(
    parameter int HALF_DIV = `SCLK_HALF_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic sclk_out,
    output logic sclk_oe_n,
    output logic mosi_out,
    output logic mosi_oe_n,
    output logic ss_out,
    output logic ss_oe_n,
    input wire logic miso_in
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] cfg, tx_lo, tx_mid, tx_hi;
    logic ss_ctrl, pin_en, loopback, loopback_prev, loop_whole;
    logic [7:0] next_cfg, next_tx_lo, next_tx_mid, next_tx_hi, next_rd_data;
    logic next_ss_ctrl, next_pin_en, next_loopback;
    spi_master_pkg::xfer_state_t state, next_state;
    logic [5:0] edge_cnt, next_edge_cnt;
    logic [4:0] run_len, next_run_len;
    logic run_cpha, next_run_cpha;
    logic phase, next_phase;
    logic mosi_bit, next_mosi_bit;
    logic [23:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh, rx_word, next_rx_word;
    logic next_sclk_out, next_mosi_out, next_ss_out, next_oe_n;
    logic [4:0] len_eff;
    logic [23:0] tx_word;
    logic exe_wr, start, tick, miso_s, miso_src, busy;
    logic lead, sample, drive, last_edge;

    // Two sync flops plus sampling need three cycles per half period
    if (HALF_DIV < 3) begin : bad_half_div
        $error("HALF_DIV must be at least three");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    sync_two_flop miso_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in(miso_in),
        .sync_out(miso_s)
    );

    half_period_ticker #(.HALF_DIV(HALF_DIV)) ticker (
        .mclk(mclk),
        .rst(rst),
        .run(state == spi_master_pkg::ST_SHIFT),
        .tick(tick)
    );

    // Out-of-range lengths clamp rather than hang the engine
    always_comb begin
        if (cfg[`CFG_LEN_MSB:`CFG_LEN_LSB] == 5'd0) begin
            len_eff = 5'd1;
        end else if (cfg[`CFG_LEN_MSB:`CFG_LEN_LSB] > 5'(`MAX_XFER_BITS)) begin
            len_eff = 5'(`MAX_XFER_BITS);
        end else begin
            len_eff = cfg[`CFG_LEN_MSB:`CFG_LEN_LSB];
        end
    end

    assign tx_word = {tx_hi, tx_mid, tx_lo};
    assign busy = (state != spi_master_pkg::ST_IDLE);
    assign exe_wr = wr_en && (addr == `OFS_SERIAL_EXECUTE_CONTROL);
    // Go ignored while busy; select level still updates
    assign start = exe_wr && wr_data[`EXE_GO_BIT] && !busy;
    assign miso_src = loopback ? mosi_bit : miso_s;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_comb begin
        next_cfg = cfg;
        next_tx_lo = tx_lo;
        next_tx_mid = tx_mid;
        next_tx_hi = tx_hi;
        next_ss_ctrl = ss_ctrl;
        next_pin_en = pin_en;
        next_loopback = loopback;
        next_rd_data = 8'h00;
        if (wr_en) begin
            if (addr == `OFS_SERIAL_MASTER_CONFIG) begin
                next_cfg = wr_data;
            end else if (addr == `OFS_SERIAL_TX_BYTE_LOW) begin
                next_tx_lo = wr_data;
            end else if (addr == `OFS_SERIAL_TX_BYTE_MID) begin
                next_tx_mid = wr_data;
            end else if (addr == `OFS_SERIAL_TX_BYTE_HIGH) begin
                next_tx_hi = wr_data;
            end else if (addr == `OFS_SERIAL_EXECUTE_CONTROL) begin
                next_ss_ctrl = wr_data[`EXE_SS_BIT];
            end else if (addr == `OFS_PIN_FUNCTION_CONFIG) begin
                next_pin_en = wr_data[`PINCFG_MASTER_EN_BIT];
            end else if (addr == `OFS_COMM_DIAGNOSTIC_CONTROL) begin
                next_loopback = wr_data[`DIAG_LOOPBACK_BIT];
            end
        end
        if (rd_en) begin
            if (addr == `OFS_SERIAL_MASTER_CONFIG) begin
                next_rd_data = cfg;
            end else if (addr == `OFS_SERIAL_TX_BYTE_LOW) begin
                next_rd_data = tx_lo;
            end else if (addr == `OFS_SERIAL_TX_BYTE_MID) begin
                next_rd_data = tx_mid;
            end else if (addr == `OFS_SERIAL_TX_BYTE_HIGH) begin
                next_rd_data = tx_hi;
            end else if (addr == `OFS_SERIAL_EXECUTE_CONTROL) begin
                next_rd_data = {6'h00, ss_ctrl, 1'b0};
            end else if (addr == `OFS_SERIAL_RX_BYTE_LOW) begin
                next_rd_data = rx_word[7:0];
            end else if (addr == `OFS_SERIAL_RX_BYTE_MID) begin
                next_rd_data = rx_word[15:8];
            end else if (addr == `OFS_SERIAL_RX_BYTE_HIGH) begin
                next_rd_data = rx_word[23:16];
            end else if (addr == `OFS_PIN_FUNCTION_CONFIG) begin
                next_rd_data = {7'h00, pin_en};
            end else if (addr == `OFS_COMM_DIAGNOSTIC_CONTROL) begin
                next_rd_data = {7'h00, loopback};
            end else if (addr == `OFS_SERIAL_STATUS) begin
                next_rd_data = {6'h00, ss_out, busy};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg <= `RST_SERIAL_MASTER_CONFIG;
            tx_lo <= `RST_BYTE;
            tx_mid <= `RST_BYTE;
            tx_hi <= `RST_BYTE;
            ss_ctrl <= 1'b1;
            pin_en <= 1'b0;
            loopback <= 1'b0;
            loopback_prev <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            cfg <= next_cfg;
            tx_lo <= next_tx_lo;
            tx_mid <= next_tx_mid;
            tx_hi <= next_tx_hi;
            ss_ctrl <= next_ss_ctrl;
            pin_en <= next_pin_en;
            loopback <= next_loopback;
            loopback_prev <= loopback;
            rd_data <= next_rd_data;
        end
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    assign lead = !edge_cnt[0];
    assign sample = lead ^ run_cpha;
    assign last_edge = (edge_cnt == {run_len, 1'b0} - 6'd1);
    // No data change after the final trailing edge
    assign drive = !sample && !last_edge;

    always_comb begin
        next_state = state;
        next_edge_cnt = edge_cnt;
        next_run_len = run_len;
        next_run_cpha = run_cpha;
        next_phase = phase;
        next_mosi_bit = mosi_bit;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_rx_word = rx_word;
        case (state)
            spi_master_pkg::ST_IDLE: begin
                if (start) begin
                    next_state = spi_master_pkg::ST_SHIFT;
                    next_edge_cnt = 6'd0;
                    next_run_len = len_eff;
                    next_run_cpha = cfg[`CFG_CPHA_BIT];
                    next_phase = 1'b0;
                    next_rx_sh = 24'h000000;
                    next_tx_sh = tx_word << (5'(`MAX_XFER_BITS) - len_eff);
                    if (!cfg[`CFG_CPHA_BIT]) begin
                        next_mosi_bit = next_tx_sh[23];
                        next_tx_sh = {next_tx_sh[22:0], 1'b0};
                    end
                end
            end
            spi_master_pkg::ST_SHIFT: begin
                if (tick) begin
                    next_phase = !phase;
                    next_edge_cnt = edge_cnt + 6'd1;
                    if (sample) begin
                        next_rx_sh = {rx_sh[22:0], miso_src};
                    end
                    if (drive) begin
                        next_mosi_bit = tx_sh[23];
                        next_tx_sh = {tx_sh[22:0], 1'b0};
                    end
                    if (last_edge) begin
                        next_state = spi_master_pkg::ST_DONE;
                    end
                end
            end
            spi_master_pkg::ST_DONE: begin
                next_rx_word = rx_sh;
                next_state = spi_master_pkg::ST_IDLE;
            end
            default: begin
                next_state = spi_master_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= spi_master_pkg::ST_IDLE;
            edge_cnt <= 6'd0;
            run_len <= 5'd1;
            run_cpha <= 1'b0;
            phase <= 1'b0;
            mosi_bit <= 1'b0;
            tx_sh <= 24'h000000;
            rx_sh <= 24'h000000;
            rx_word <= 24'h000000;
        end else begin
            state <= next_state;
            edge_cnt <= next_edge_cnt;
            run_len <= next_run_len;
            run_cpha <= next_run_cpha;
            phase <= next_phase;
            mosi_bit <= next_mosi_bit;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            rx_word <= next_rx_word;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Pins hold while looped back; a polarity change then would glitch them
    always_comb begin
        next_oe_n = !pin_en;
        next_sclk_out = sclk_out;
        next_mosi_out = mosi_out;
        next_ss_out = ss_out;
        if (!loopback) begin
            next_sclk_out = cfg[`CFG_CPOL_BIT] ^ next_phase;
            next_mosi_out = next_mosi_bit;
            next_ss_out = ss_ctrl;
        end else if (!loopback_prev) begin
            next_ss_out = ss_ctrl;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_out <= 1'b0;
            mosi_out <= 1'b0;
            ss_out <= 1'b1;
            sclk_oe_n <= 1'b1;
            mosi_oe_n <= 1'b1;
            ss_oe_n <= 1'b1;
        end else begin
            sclk_out <= next_sclk_out;
            mosi_out <= next_mosi_out;
            ss_out <= next_ss_out;
            sclk_oe_n <= next_oe_n;
            mosi_oe_n <= next_oe_n;
            ss_oe_n <= next_oe_n;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int MAX_FRAME = 400;
    logic [6:0] tick_seen;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_seen <= 7'd0;
            loop_whole <= 1'b0;
        end else if (start) begin
            tick_seen <= 7'd0;
            loop_whole <= loopback;
        end else begin
            if (tick && state == spi_master_pkg::ST_SHIFT) begin
                tick_seen <= tick_seen + 7'd1;
            end
            if (!loopback) begin
                loop_whole <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_START_BUSY: assert property (
        start |=> state == spi_master_pkg::ST_SHIFT
    ) else $error("Go write did not start a transfer");

    AST_EDGE_COUNT: assert property (
        state == spi_master_pkg::ST_DONE |-> tick_seen == {1'b0, run_len, 1'b0}
    ) else $error("Clock edge count differs from length");

    AST_FRAME_ENDS: assert property (
        start |=> busy ##[1:MAX_FRAME] !busy
    ) else $error("Transfer did not finish in time");

    AST_PINS_RELEASED: assert property (
        !pin_en ##1 !pin_en |-> sclk_oe_n && mosi_oe_n && ss_oe_n
    ) else $error("Pins driven while master port disabled");

    AST_IDLE_POLARITY: assert property (
        (!busy && !loopback) [*3] |-> sclk_out == $past(cfg[`CFG_CPOL_BIT])
    ) else $error("Idle clock level does not match polarity");

    AST_SELECT_LEVEL: assert property (
        (exe_wr && !loopback ##1 !exe_wr && !loopback ##1 !loopback)
            |-> ss_out == $past(wr_data[`EXE_SS_BIT], 2)
    ) else $error("Select pin does not follow control");

    AST_LOOP_FROZEN: assert property (
        loopback && loopback_prev |=> $stable(sclk_out) && $stable(mosi_out)
            && $stable(ss_out)
    ) else $error("External pins moved during loopback");

    AST_LOOP_LATCH: assert property (
        $rose(loopback) |=> ss_out == $past(ss_ctrl)
    ) else $error("Select not latched on loopback entry");

    AST_LOOP_DATA: assert property (
        state == spi_master_pkg::ST_DONE && loop_whole
            |=> rx_word == ((tx_word << (5'd24 - run_len)) >> (5'd24 - run_len))
    ) else $error("Loopback receive differs from transmit");
endmodule

// File: serial_slave_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side serial slave
// ----------------------------------------
module serial_slave_model (
    input wire logic ss,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [4:0] bits,
    input wire logic [23:0] word,
    output logic miso,
    output logic [23:0] rx
);
    int bi = 0;
    initial begin
        miso = 1'b0;
        rx = 24'h000000;
    end
    // First bit must already stand before a leading-edge sample
    always @(negedge ss) begin
        bi = int'(bits) - 1;
        rx = 24'h000000;
        if (!cpha) begin
            miso = word[bi];
        end
    end
    // Released line: last driven bit is inverted, not cleared
    always @(posedge ss) begin
        miso = ~miso;
    end
    always @(sclk) begin
        if (ss === 1'b0) begin
            if ((sclk != cpol) ^ cpha) begin
                rx = {rx[22:0], mosi};
            end else begin
                if (!cpha) begin
                    bi = bi - 1;
                end
                if (bi >= 0) begin
                    miso = word[bi];
                end
                if (cpha) begin
                    bi = bi - 1;
                end
            end
        end
    end
endmodule

// File: test_register_driven_spi_master.sv
`timescale 1ns/100ps
`include "spi_master_regs.svh"
module test_register_driven_spi_master;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, ss_out, ss_oe_n;
    logic sclk_w, mosi_w, ss_w, miso_w;
    logic s_cpol = 1'b0;
    logic s_cpha = 1'b0;
    logic [4:0] s_bits = 5'h08;
    logic [23:0] s_word = 24'h000000;
    logic [23:0] s_rx;
    logic [23:0] exp_q [$];
    logic prev_sclk = 1'b0;
    logic watch = 1'b0;
    logic moved = 1'b0;
    logic [2:0] held = 3'h0;
    logic [31:0] seed = 32'd38136;
    logic [7:0] b;
    logic [7:0] rst_tab [12] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h02, 8'h00};
    int lens [4] = '{1, 24, 7, 13};
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int edges = 0;

    always #10 mclk = ~mclk;
    // Pull-ups hold released pins high
    assign sclk_w = sclk_oe_n ? 1'b1 : sclk_out;
    assign mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
    assign ss_w = ss_oe_n ? 1'b1 : ss_out;

    register_driven_spi_master #(.HALF_DIV(4)) dut (.mclk(mclk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .ss_out(ss_out), .ss_oe_n(ss_oe_n), .miso_in(miso_w));

    serial_slave_model slave (.ss(ss_w), .sclk(sclk_w), .mosi(mosi_w), .cpol(s_cpol),
        .cpha(s_cpha), .bits(s_bits), .word(s_word), .miso(miso_w), .rx(s_rx));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // ----------------------------------------
    // One transfer, checked against the integer model
    // ----------------------------------------
    task automatic xfer(input logic pol, input logic pha, input int n, input logic lb);
        logic [23:0] tx;
        logic [23:0] mask;
        logic [7:0] r0, r1, r2, st;
        int k;
        seed = xs(seed);
        tx = seed[23:0];
        seed = xs(seed);
        mask = (24'h000001 << n) - 24'h000001;
        s_cpol = pol;
        s_cpha = pha;
        s_bits = n[4:0];
        s_word = seed[23:0];
        exp_q.push_back(lb ? (tx & mask) : (s_word & mask));
        wr(`OFS_SERIAL_MASTER_CONFIG, {1'b0, pol, pha, n[4:0]});
        wr(`OFS_SERIAL_TX_BYTE_LOW, tx[7:0]);
        wr(`OFS_SERIAL_TX_BYTE_MID, tx[15:8]);
        wr(`OFS_SERIAL_TX_BYTE_HIGH, tx[23:16]);
        if (!lb) begin
            chk(sclk_out, pol);
        end
        edges = 0;
        wr(`OFS_SERIAL_EXECUTE_CONTROL, 8'h01);
        rd(`OFS_SERIAL_STATUS, st);
        chk(st, {6'h00, lb, 1'b1});
        // Go while busy must not restart the frame
        wr(`OFS_SERIAL_EXECUTE_CONTROL, 8'h01);
        chk(ss_w, lb);
        k = 0;
        while (st[0] !== 1'b0 && k < 200) begin
            rd(`OFS_SERIAL_STATUS, st);
            k++;
        end
        chk(st[0], 1'b0);
        chk(edges, lb ? 0 : 2 * n);
        rd(`OFS_SERIAL_RX_BYTE_LOW, r0);
        rd(`OFS_SERIAL_RX_BYTE_MID, r1);
        rd(`OFS_SERIAL_RX_BYTE_HIGH, r2);
        chk({r2, r1, r0}, exp_q.pop_front());
        if (!lb) begin
            chk(s_rx & mask, tx & mask);
        end
        wr(`OFS_SERIAL_EXECUTE_CONTROL, 8'h02);
        @(posedge mclk);
        #1 chk(ss_out, 1'b1);
        $display("transfer done: cpol=%0d cpha=%0d bits=%0d loop=%0d", pol, pha, n, lb);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            summarize();
        end
    end

    always @(posedge mclk) begin
        if (sclk_out !== prev_sclk) begin
            edges++;
        end
        prev_sclk = sclk_out;
        if (watch && {sclk_out, mosi_out, ss_out} !== held) begin
            moved = 1'b1;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({sclk_oe_n, mosi_oe_n, ss_oe_n}, 3'h7);
        for (int i = 0; i < 12; i++) begin
            rd(i[7:0], b);
            chk(b, rst_tab[i]);
        end
        wr(`OFS_SERIAL_RX_BYTE_LOW, 8'hff);
        rd(`OFS_SERIAL_RX_BYTE_LOW, b);
        chk(b, 8'h00);
        $display("register reset test done");
        wr(`OFS_PIN_FUNCTION_CONFIG, 8'h01);
        @(posedge mclk);
        #1 chk({sclk_oe_n, mosi_oe_n, ss_oe_n}, 3'h0);
        for (int m = 0; m < 4; m++) begin
            xfer(m[1], m[0], lens[m], 1'b0);
        end
        for (int m = 0; m < 4; m++) begin
            seed = xs(seed);
            xfer(seed[9], seed[8], int'(seed[7:0] % 24) + 1, 1'b0);
        end
        xfer(1'b0, 1'b0, 8, 1'b0);
        // Same polarity and phase as the last frame, so loopback sees no glitch
        wr(`OFS_COMM_DIAGNOSTIC_CONTROL, 8'h01);
        held = {sclk_out, mosi_out, ss_out};
        watch = 1'b1;
        xfer(1'b0, 1'b0, 24, 1'b1);
        xfer(1'b0, 1'b0, 5, 1'b1);
        watch = 1'b0;
        chk(moved, 1'b0);
        chk(ss_out, 1'b1);
        wr(`OFS_COMM_DIAGNOSTIC_CONTROL, 8'h00);
        wr(`OFS_PIN_FUNCTION_CONFIG, 8'h00);
        @(posedge mclk);
        #1 chk({sclk_oe_n, mosi_oe_n, ss_oe_n}, 3'h7);
        $display("loopback and release test done");
        summarize();
    end
endmodule
